// ---- src/tirq_pkg.sv ----
package tirq_pkg;
  localparam int unsigned TIRQ_AW = 32;
  localparam int unsigned TIRQ_DW = 32;
  // Register byte addresses
  localparam logic [31:0] TIRQ_IRQ_ENABLE_SET_ADDR = 32'h4005_0008;
  localparam logic [31:0] TIRQ_IRQ_ENABLE_CLEAR_ADDR = 32'h4005_000C;
  localparam logic [31:0] TIRQ_EVT_STATUS_ADDR = 32'h4005_0040;
  localparam logic [31:0] TIRQ_EVT_CLEAR_ADDR = 32'h4005_0044;
  localparam logic [31:0] TIRQ_EVT_ENABLE_ADDR = 32'h4005_0048;
  // Enable bit positions
  localparam int unsigned TIRQ_MASTER_WAITING_BIT = 0;
  localparam int unsigned TIRQ_MASTER_LOST_ARB_BIT = 4;
  localparam int unsigned TIRQ_MASTER_FRAMING_BIT = 6;
  localparam int unsigned TIRQ_TARGET_WAITING_BIT = 8;
  localparam int unsigned TIRQ_TARGET_NOT_HOLDING_BIT = 11;
  localparam int unsigned TIRQ_TARGET_UNSELECTED_BIT = 15;
  localparam int unsigned TIRQ_SNOOP_READY_BIT = 16;
  localparam int unsigned TIRQ_SNOOP_OVERRUN_BIT = 17;
  localparam int unsigned TIRQ_SNOOP_QUIET_BIT = 19;
  localparam int unsigned TIRQ_BUS_GAP_TIMEOUT_BIT = 24;
  localparam int unsigned TIRQ_CLOCK_LOW_TIMEOUT_BIT = 25;
  // Implemented enables; everything else reserved
  localparam logic [31:0] TIRQ_ENABLE_MASK = 32'h030B_8951;
  localparam logic [31:0] TIRQ_ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] TIRQ_ZERO_WORD = 32'h0000_0000;
  // Wrapper event bits
  localparam int unsigned TIRQ_EVT_W = 2;
  localparam int unsigned TIRQ_EVT_IRQ_RISE_BIT = 0;
  localparam int unsigned TIRQ_EVT_ENABLE_DROP_BIT = 1;
  localparam logic [TIRQ_EVT_W-1:0] TIRQ_EVT_RESET = 2'h0;
endpackage : tirq_pkg

// ---- src/tirq_sticky.sv ----
`timescale 1ns/100ps
module tirq_sticky
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic q_o
);
  logic q_r;
  logic q_nxt;

  // Set wins over a same-cycle clear
  always_comb
  begin
    q_nxt = q_r;
    if (clr_i)
    begin
      q_nxt = 1'b0;
    end
    if (set_i)
    begin
      q_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_r <= 1'b0;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule : tirq_sticky

// ---- src/tirq_top.sv ----
// Contract
// - Write one to set register enables
// - Set register reads current enables
// - Master enables at bits 0,4,6
// - Target enables at bits 8,11,15
// - Snoop enables at bits 16,17,19
// - Timeout enables at bits 24,25
// - All enables zero after reset
// - Write one to clear register disables
// - Clear register is write only
// - Clear uses same bit layout
// - Bus gap timeout needs its enable
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
module tirq_top
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [tirq_pkg::TIRQ_AW-1:0] addr_i,
  input wire logic [tirq_pkg::TIRQ_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [tirq_pkg::TIRQ_DW-1:0] status_flags_i,
  output logic [tirq_pkg::TIRQ_DW-1:0] rdata_o,
  output logic twi_irq_o,
  output logic [tirq_pkg::TIRQ_DW-1:0] enables_o,
  output logic evt_irq_o
);
  import tirq_pkg::*;

  logic [TIRQ_DW-1:0] enable_r;
  logic [TIRQ_DW-1:0] enable_nxt;
  logic [TIRQ_DW-1:0] rdata_r;
  logic [TIRQ_DW-1:0] rdata_nxt;
  logic twi_irq_r;
  logic twi_irq_nxt;
  logic [TIRQ_EVT_W-1:0] evt_en_r;
  logic [TIRQ_EVT_W-1:0] evt_en_nxt;
  logic evt_irq_r;
  logic evt_irq_nxt;
  logic [TIRQ_EVT_W-1:0] evt_status;
  logic [TIRQ_EVT_W-1:0] evt_set;
  logic [TIRQ_EVT_W-1:0] evt_clr;
  logic wr_set;
  logic wr_clr;
  logic wr_evt_clr;
  logic wr_evt_en;
  logic [TIRQ_DW-1:0] evt_status_word;
  logic [TIRQ_DW-1:0] evt_enable_word;

  // Named enable bits
  logic master_waiting_irq_enable;
  logic master_lost_arbitration_irq_enable;
  logic master_framing_error_irq_enable;
  logic target_waiting_irq_enable;
  logic target_not_holding_irq_enable;
  logic target_unselected_irq_enable;
  logic snoop_ready_irq_enable;
  logic snoop_overrun_irq_enable;
  logic snoop_quiet_irq_enable;
  logic bus_gap_timeout_irq_enable;
  logic clock_low_timeout_irq_enable;

  // Named clear strokes
  logic master_waiting_irq_disable;
  logic master_lost_arbitration_irq_disable;
  logic master_framing_error_irq_disable;
  logic target_waiting_irq_disable;
  logic target_not_holding_irq_disable;
  logic target_unselected_irq_disable;
  logic snoop_ready_irq_disable;
  logic snoop_overrun_irq_disable;
  logic snoop_quiet_irq_disable;
  logic bus_gap_timeout_irq_disable;
  logic clock_low_timeout_irq_disable;

  // Gated request per source
  logic master_waiting_req;
  logic master_lost_arbitration_req;
  logic master_framing_error_req;
  logic target_waiting_req;
  logic target_not_holding_req;
  logic target_unselected_req;
  logic snoop_ready_req;
  logic snoop_overrun_req;
  logic snoop_quiet_req;
  logic bus_gap_timeout_req;
  logic clock_low_timeout_req;
  logic enable_drop;

  assign wr_set = wr_i && (addr_i == TIRQ_IRQ_ENABLE_SET_ADDR);
  assign wr_clr = wr_i && (addr_i == TIRQ_IRQ_ENABLE_CLEAR_ADDR);
  assign wr_evt_clr = wr_i && (addr_i == TIRQ_EVT_CLEAR_ADDR);
  assign wr_evt_en = wr_i && (addr_i == TIRQ_EVT_ENABLE_ADDR);

  // Named views of the enable word
  assign master_waiting_irq_enable = enable_r[TIRQ_MASTER_WAITING_BIT];
  assign master_lost_arbitration_irq_enable = enable_r[TIRQ_MASTER_LOST_ARB_BIT];
  assign master_framing_error_irq_enable = enable_r[TIRQ_MASTER_FRAMING_BIT];
  assign target_waiting_irq_enable = enable_r[TIRQ_TARGET_WAITING_BIT];
  assign target_not_holding_irq_enable = enable_r[TIRQ_TARGET_NOT_HOLDING_BIT];
  assign target_unselected_irq_enable = enable_r[TIRQ_TARGET_UNSELECTED_BIT];
  assign snoop_ready_irq_enable = enable_r[TIRQ_SNOOP_READY_BIT];
  assign snoop_overrun_irq_enable = enable_r[TIRQ_SNOOP_OVERRUN_BIT];
  assign snoop_quiet_irq_enable = enable_r[TIRQ_SNOOP_QUIET_BIT];
  assign bus_gap_timeout_irq_enable = enable_r[TIRQ_BUS_GAP_TIMEOUT_BIT];
  assign clock_low_timeout_irq_enable = enable_r[TIRQ_CLOCK_LOW_TIMEOUT_BIT];

  // Clear register strokes, one per source
  assign master_waiting_irq_disable = wr_clr && wdata_i[TIRQ_MASTER_WAITING_BIT];
  assign master_lost_arbitration_irq_disable = wr_clr && wdata_i[TIRQ_MASTER_LOST_ARB_BIT];
  assign master_framing_error_irq_disable = wr_clr && wdata_i[TIRQ_MASTER_FRAMING_BIT];
  assign target_waiting_irq_disable = wr_clr && wdata_i[TIRQ_TARGET_WAITING_BIT];
  assign target_not_holding_irq_disable = wr_clr && wdata_i[TIRQ_TARGET_NOT_HOLDING_BIT];
  assign target_unselected_irq_disable = wr_clr && wdata_i[TIRQ_TARGET_UNSELECTED_BIT];
  assign snoop_ready_irq_disable = wr_clr && wdata_i[TIRQ_SNOOP_READY_BIT];
  assign snoop_overrun_irq_disable = wr_clr && wdata_i[TIRQ_SNOOP_OVERRUN_BIT];
  assign snoop_quiet_irq_disable = wr_clr && wdata_i[TIRQ_SNOOP_QUIET_BIT];
  assign bus_gap_timeout_irq_disable = wr_clr && wdata_i[TIRQ_BUS_GAP_TIMEOUT_BIT];
  assign clock_low_timeout_irq_disable = wr_clr && wdata_i[TIRQ_CLOCK_LOW_TIMEOUT_BIT];

  // Enable register: set and clear act through the same layout
  always_comb
  begin
    enable_nxt = enable_r;
    if (wr_set)
    begin
      enable_nxt = enable_r | (wdata_i & TIRQ_ENABLE_MASK);
    end
    if (wr_clr)
    begin
      enable_nxt = enable_r & ~(wdata_i & TIRQ_ENABLE_MASK);
    end
    // Only implemented positions can hold a one
    enable_nxt = enable_nxt & TIRQ_ENABLE_MASK;
  end

  // Request gated per position; gap timeout only with its enable
  always_comb
  begin
    master_waiting_req = status_flags_i[TIRQ_MASTER_WAITING_BIT]
      && master_waiting_irq_enable;
    master_lost_arbitration_req = status_flags_i[TIRQ_MASTER_LOST_ARB_BIT]
      && master_lost_arbitration_irq_enable;
    master_framing_error_req = status_flags_i[TIRQ_MASTER_FRAMING_BIT]
      && master_framing_error_irq_enable;
    target_waiting_req = status_flags_i[TIRQ_TARGET_WAITING_BIT]
      && target_waiting_irq_enable;
    target_not_holding_req = status_flags_i[TIRQ_TARGET_NOT_HOLDING_BIT]
      && target_not_holding_irq_enable;
    target_unselected_req = status_flags_i[TIRQ_TARGET_UNSELECTED_BIT]
      && target_unselected_irq_enable;
    snoop_ready_req = status_flags_i[TIRQ_SNOOP_READY_BIT]
      && snoop_ready_irq_enable;
    snoop_overrun_req = status_flags_i[TIRQ_SNOOP_OVERRUN_BIT]
      && snoop_overrun_irq_enable;
    snoop_quiet_req = status_flags_i[TIRQ_SNOOP_QUIET_BIT]
      && snoop_quiet_irq_enable;
    bus_gap_timeout_req = status_flags_i[TIRQ_BUS_GAP_TIMEOUT_BIT]
      && bus_gap_timeout_irq_enable;
    clock_low_timeout_req = status_flags_i[TIRQ_CLOCK_LOW_TIMEOUT_BIT]
      && clock_low_timeout_irq_enable;
    twi_irq_nxt = master_waiting_req
      || master_lost_arbitration_req
      || master_framing_error_req
      || target_waiting_req
      || target_not_holding_req
      || target_unselected_req
      || snoop_ready_req
      || snoop_overrun_req
      || snoop_quiet_req
      || bus_gap_timeout_req
      || clock_low_timeout_req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable_r <= TIRQ_ENABLE_RESET;
      twi_irq_r <= 1'b0;
    end
    else
    begin
      enable_r <= enable_nxt;
      twi_irq_r <= twi_irq_nxt;
    end
  end

  // A clear stroke that lands on a live enable
  always_comb
  begin
    enable_drop = (master_waiting_irq_disable && master_waiting_irq_enable)
      || (master_lost_arbitration_irq_disable && master_lost_arbitration_irq_enable)
      || (master_framing_error_irq_disable && master_framing_error_irq_enable)
      || (target_waiting_irq_disable && target_waiting_irq_enable)
      || (target_not_holding_irq_disable && target_not_holding_irq_enable)
      || (target_unselected_irq_disable && target_unselected_irq_enable)
      || (snoop_ready_irq_disable && snoop_ready_irq_enable)
      || (snoop_overrun_irq_disable && snoop_overrun_irq_enable)
      || (snoop_quiet_irq_disable && snoop_quiet_irq_enable)
      || (bus_gap_timeout_irq_disable && bus_gap_timeout_irq_enable)
      || (clock_low_timeout_irq_disable && clock_low_timeout_irq_enable);
  end

  // Wrapper events: request rising, and an enable dropped by software
  always_comb
  begin
    evt_set = TIRQ_EVT_RESET;
    evt_set[TIRQ_EVT_IRQ_RISE_BIT] = twi_irq_nxt && !twi_irq_r;
    evt_set[TIRQ_EVT_ENABLE_DROP_BIT] = enable_drop;
    evt_clr = TIRQ_EVT_RESET;
    if (wr_evt_clr)
    begin
      evt_clr = wdata_i[TIRQ_EVT_W-1:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < TIRQ_EVT_W; g++)
    begin : g_evt
      tirq_sticky u_sticky
      (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(evt_set[g]),
        .clr_i(evt_clr[g]),
        .q_o(evt_status[g])
      );
    end
  endgenerate

  always_comb
  begin
    evt_en_nxt = evt_en_r;
    if (wr_evt_en)
    begin
      evt_en_nxt = wdata_i[TIRQ_EVT_W-1:0];
    end
    evt_irq_nxt = |(evt_status & evt_en_r);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      evt_en_r <= TIRQ_EVT_RESET;
      evt_irq_r <= 1'b0;
    end
    else
    begin
      evt_en_r <= evt_en_nxt;
      evt_irq_r <= evt_irq_nxt;
    end
  end

  // Event registers widened to a bus word
  assign evt_status_word = {{(TIRQ_DW-TIRQ_EVT_W){1'b0}}, evt_status};
  assign evt_enable_word = {{(TIRQ_DW-TIRQ_EVT_W){1'b0}}, evt_en_r};

  // Read data valid the cycle after the strobe only
  always_comb
  begin
    rdata_nxt = TIRQ_ZERO_WORD;
    if (rd_i)
    begin
      case (addr_i)
        TIRQ_IRQ_ENABLE_SET_ADDR:
        begin
          rdata_nxt = enable_r;
        end
        TIRQ_IRQ_ENABLE_CLEAR_ADDR:
        begin
          rdata_nxt = TIRQ_ZERO_WORD;
        end
        TIRQ_EVT_STATUS_ADDR:
        begin
          rdata_nxt = evt_status_word;
        end
        TIRQ_EVT_ENABLE_ADDR:
        begin
          rdata_nxt = evt_enable_word;
        end
        default:
        begin
          rdata_nxt = TIRQ_ZERO_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_r <= TIRQ_ZERO_WORD;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign twi_irq_o = twi_irq_r;
  assign enables_o = enable_r;
  assign evt_irq_o = evt_irq_r;
endmodule : tirq_top

// ---- tb/tirq_monitor.sv ----
`timescale 1ns/100ps
module tirq_monitor
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] status_flags_i,
  input wire logic [31:0] rdata_o,
  input wire logic twi_irq_o,
  input wire logic [31:0] enables_o,
  input wire logic evt_irq_o
);
  import tirq_pkg::*;
  wire ws = wr_i && addr_i == TIRQ_IRQ_ENABLE_SET_ADDR;
  wire wc = wr_i && addr_i == TIRQ_IRQ_ENABLE_CLEAR_ADDR;
  logic [31:0] hit_r;
  always_ff @(posedge clk_i)
  begin
    hit_r <= rst_i ? 32'h0 : status_flags_i & enables_o;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_set; ws |=> enables_o == ($past(enables_o) | ($past(wdata_i) & 32'h030B8951)); endproperty
  a_set: assert property (p_set) else $error("set");
  property p_rd; rd_i && addr_i == TIRQ_IRQ_ENABLE_SET_ADDR |=> rdata_o == $past(enables_o); endproperty
  a_rd: assert property (p_rd) else $error("rd");
  property p_rsv; (enables_o & 32'hFCF4_76AE) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("rsv");
  property p_rst; $fell(rst_i) |-> enables_o == 32'h0 && !twi_irq_o; endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_clr; wc |=> enables_o == ($past(enables_o) & ~$past(wdata_i)); endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_wo; rd_i && addr_i == TIRQ_IRQ_ENABLE_CLEAR_ADDR |=> rdata_o == 32'h0; endproperty
  a_wo: assert property (p_wo) else $error("wo");
  property p_gap; !enables_o[24] && status_flags_i == 32'h0100_0000 |=> !twi_irq_o; endproperty
  a_gap: assert property (p_gap) else $error("gap");
  property p_irq; twi_irq_o == |hit_r; endproperty
  a_irq: assert property (p_irq) else $error("irq");
  c_set: cover property (ws);
  c_clr: cover property (wc);
  c_irq: cover property ($rose(twi_irq_o));
  c_evt: cover property ($rose(evt_irq_o));
endmodule : tirq_monitor

// ---- tb/test_tirq_top.sv ----
`timescale 1ns/100ps
module test_tirq_top;
  import tirq_pkg::*;
  logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, twi_irq_o, evt_irq_o;
  logic [31:0] addr_i = 0, wdata_i = 0, status_flags_i = 0, rdata_o, enables_o;
  int num_errors = 0, checks_done = 0;
  tirq_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .status_flags_i(status_flags_i), .rdata_o(rdata_o),
    .twi_irq_o(twi_irq_o), .enables_o(enables_o), .evt_irq_o(evt_irq_o));
  initial forever #50 clk_i = ~clk_i;
  task automatic ck(input logic [31:0] g, e);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : ck
  task automatic wr(input logic [31:0] a, d);
    @(posedge clk_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'h0;
  endtask : wr
  task automatic rd(input logic [31:0] a, e);
    @(posedge clk_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'h0;
    #1 ck(rdata_o, e);
    @(posedge clk_i);
    #1 ck(rdata_o, 32'h0);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt
  task automatic t_pos;
    int p[11] = '{0, 4, 6, 8, 11, 15, 16, 17, 19, 24, 25};
    logic [31:0] e;
    e = 32'h0;
    ck(enables_o, e);
    rd(TIRQ_IRQ_ENABLE_SET_ADDR, e);
    foreach (p[i])
    begin
      e = e | (32'h1 << p[i]);
      wr(TIRQ_IRQ_ENABLE_SET_ADDR, 32'h1 << p[i]);
      rd(TIRQ_IRQ_ENABLE_SET_ADDR, e);
    end
    rd(TIRQ_IRQ_ENABLE_CLEAR_ADDR, 32'h0);
    wr(TIRQ_IRQ_ENABLE_CLEAR_ADDR, 32'h0209_0801);
    rd(TIRQ_IRQ_ENABLE_SET_ADDR, 32'h0102_8150);
    wr(TIRQ_IRQ_ENABLE_SET_ADDR, 32'h0);
    rd(TIRQ_IRQ_ENABLE_SET_ADDR, 32'h0102_8150);
    rd(32'h4005_0020, 32'h0);
  endtask : t_pos
  task automatic t_irq;
    wr(TIRQ_IRQ_ENABLE_CLEAR_ADDR, 32'h030B_8951);
    status_flags_i <= 32'h0100_0000;
    wt(3);
    ck(twi_irq_o, 1'h0);
    wr(TIRQ_IRQ_ENABLE_SET_ADDR, 32'h0100_0000);
    wt(1);
    ck(twi_irq_o, 1'h1);
    wr(TIRQ_EVT_ENABLE_ADDR, 32'h1);
    wt(1);
    ck(evt_irq_o, 1'h1);
    wr(TIRQ_EVT_CLEAR_ADDR, 32'h1);
    wt(1);
    ck(evt_irq_o, 1'h0);
    wr(TIRQ_IRQ_ENABLE_CLEAR_ADDR, 32'h0100_0000);
    wt(1);
    ck(twi_irq_o, 1'h0);
    rd(TIRQ_EVT_STATUS_ADDR, 32'h2);
    rd(TIRQ_EVT_ENABLE_ADDR, 32'h1);
    wr(TIRQ_EVT_CLEAR_ADDR, 32'h2);
    rd(TIRQ_EVT_STATUS_ADDR, 32'h0);
  endtask : t_irq
  task automatic t_rst;
    wr(TIRQ_IRQ_ENABLE_SET_ADDR, TIRQ_ENABLE_MASK);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    #1 ck(enables_o, 32'h0);
    ck(twi_irq_o, 1'h0);
    ck(evt_irq_o, 1'h0);
    rd(TIRQ_IRQ_ENABLE_SET_ADDR, 32'h0);
  endtask : t_rst
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    t_pos;
    t_irq;
    t_rst;
    finish_test;
  end
  initial
  begin
    repeat (3000) @(posedge clk_i);
    num_errors++;
    finish_test;
  end
endmodule : test_tirq_top
bind tirq_top tirq_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .status_flags_i(status_flags_i),
  .rdata_o(rdata_o), .twi_irq_o(twi_irq_o), .enables_o(enables_o), .evt_irq_o(evt_irq_o));
